// File: sscl_pkg.sv
// constants shared by the synthesizer serial-control and lock-detect block
// assumes a single 40 MHz bus clock that is also the reference oscillator
package sscl_pkg;

    // serial word and control register set
    localparam int WORD_W   = 24;
    localparam int NUM_CREG = 7;
    localparam logic [23:0] CREG_RST = 24'h00_0000;  // all sections off

    // bus register offsets (byte addresses)
    localparam logic [7:0] OFS_STATUS    = 8'h00;  // read: live state
    localparam logic [7:0] OFS_WORD_LOAD = 8'h04;  // write: load a word
    localparam logic [7:0] OFS_PHASE_ERR = 8'h08;  // read: last error
    localparam logic [7:0] OFS_CREG_BASE = 8'h20;  // read: control regs

    // register-zero fields
    localparam int R0_RF_SEL  = 22;  // 1 = modulus 8, 0 = modulus 6
    localparam int R0_LD_MODE = 21;
    localparam int R0_B_LSB   = 16;
    localparam int R0_A_LSB   = 13;
    localparam int R0_FN_LSB  = 2;
    // register-one fields
    localparam int R1_SPUR_LSB = 11;
    localparam int R1_RF_SECTION_ENABLE    = 3;
    localparam int R1_IF_EN    = 2;
    // register-three fields
    localparam int R3_DUR_LSB = 22;
    localparam int R3_CRL_LSB = 20;
    localparam int R3_WIDE_BANDWIDTH_ENABLE   = 19;
    // register-four and register-five fields
    localparam int R4_A_LSB = 13;
    localparam int R4_B_LSB = 4;
    localparam int R5_R_LSB = 5;

    // divide equation constants
    localparam logic [3:0] MOD_HIGH = 4'h8;
    localparam logic [3:0] MOD_LOW  = 4'h6;
    localparam logic [4:0] IF_MOD   = 5'h10;

    // lock detect timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int LOCK_WINDOW_NS   = 10;
    localparam int UNLOCK_WINDOW_NS = 10;
    localparam int LOCK_WIN_CYC =
        (LOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UNLOCK_WIN_CYC =
        (UNLOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] LOCK_COUNT = 3'h4;
    localparam logic [5:0] CMP_LAST   = 6'h3f;  // every 64th edge

    // spur reduction settings
    localparam logic [1:0] SPUR_OFF  = 2'h0;
    localparam logic [1:0] SPUR_ONCE = 2'h1;
    localparam logic [1:0] SPUR_CONT = 2'h2;

    // lock detector states
    typedef enum logic [1:0] {
        LD_UNLOCKED = 2'b01,
        LD_LOCKED   = 2'b10
    } sscl_ld_e;

endpackage

// File: sscl_top.sv
// serial control port, control registers, power gating and lock detect
// assumes hclk is the reference oscillator; pins arrive unsynchronised
// Functional notes
// - shift serial data on each clock rise
// - trailing word bits select target register
// - strobe rise copies word into register
// - chip enable low powers both sections down
// - enable bits gate each section independently
// - lock mode bit grounds or enables output
// - lock output high locked, low unlocked
// - large phase error drops lock at once
// - four good comparisons in row raise lock
// - compare only every 64th divided edge
// - error taken between rising leading edges
// - rf divide is modulus times main plus swallow
// - fraction numerator passed, below denominator
// - if divide is sixteen times main plus swallow
// - reference divided by if reference count
// - spur compensation continuous, once, or off
// - widen bandwidth until lock, then restore
// - words shift in msb first
// - address bits 00 select register zero
`timescale 1ns/1ps

module sscl_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // pins
    input  wire logic        serial_data,
    input  wire logic        serial_clock,
    input  wire logic        serial_load_strobe,
    input  wire logic        chip_enable_pin,
    input  wire logic        ref_divided,
    input  wire logic        fb_divided,
    // section controls and status
    output logic             rf_section_enable,
    output logic             if_section_enable,
    output logic             lock_indicator_out,
    output logic [6:0]       rf_divide_value,
    output logic [10:0]      rf_fraction_numerator,
    output logic [12:0]      if_divide_value,
    output logic             if_compare_tick,
    output logic             spur_comp_update,
    output logic             wide_bandwidth,
    output logic [1:0]       wide_bandwidth_duration,
    output logic [1:0]       wide_bandwidth_control
);
    // target register from the trailing address bits of a word
    function automatic logic [2:0] creg_index(input logic [23:0] w);
        if (w[1:0] != 2'b11) begin
            creg_index = {1'b0, w[1:0]};
        end else if (w[3:2] == 2'b00) begin
            creg_index = 3'd3;
        end else if (w[3:2] == 2'b01) begin
            creg_index = 3'd4;
        end else begin
            creg_index = w[4] ? 3'd6 : 3'd5;
        end
    endfunction
    // pin synchronisers: three stages, filtered when stages 2 and 3 agree
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q, s2_q, s3_q;   // synchroniser stages
    logic [NPIN-1:0] filt_q;             // agreed pin level
    logic [NPIN-1:0] filt_d;
    logic [NPIN-1:0] rise;               // one-cycle rising pulse
    assign pin_raw = {fb_divided, ref_divided, chip_enable_pin,
                      serial_load_strobe, serial_clock, serial_data};

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_sync
            assign filt_d[gp] = (s2_q[gp] == s3_q[gp]) ? s3_q[gp] : filt_q[gp];
            assign rise[gp]   = filt_d[gp] & ~filt_q[gp];
        end
    endgenerate
    // stage chain; only stage 2 reads stage 1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else if (clk_en) begin
            s1_q   <= pin_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    wire sdat_lvl = filt_q[0];
    wire sclk_up  = rise[1];
    wire load_up  = rise[2];
    wire ce_lvl   = filt_q[3];
    wire ref_up   = rise[4];
    wire fb_up    = rise[5];
    // serial shift register, msb first
    logic [23:0] shift_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_q <= '0;
        end else if (clk_en && sclk_up) begin
            shift_q <= {shift_q[22:0], sdat_lvl};
        end
    end
    // ahb-lite slave: zero wait states, read data set in address phase
    logic        wr_pend_q;              // write data phase pending
    logic [7:0]  wr_addr_q;
    wire         take = hsel & htrans[1] & hready;
    wire  [7:0]  a_lo = haddr[7:0];
    wire         sw_load = wr_pend_q & (wr_addr_q == sscl_pkg::OFS_WORD_LOAD);
    wire  [23:0] sw_word = hwdata[23:0];
    // serial strobe wins over a software load in the same cycle
    wire         any_load = load_up | sw_load;
    wire  [23:0] new_word = load_up ? shift_q : sw_word;
    wire  [2:0]  new_idx  = creg_index(new_word);
    // control registers
    localparam int NUM_CREG = sscl_pkg::NUM_CREG;
    logic [23:0] creg_q [NUM_CREG];
    genvar gr;
    generate
        for (gr = 0; gr < NUM_CREG; gr++) begin : g_creg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    creg_q[gr] <= sscl_pkg::CREG_RST;
                end else if (clk_en && any_load && new_idx == 3'(gr)) begin
                    creg_q[gr] <= new_word;
                end
            end
        end
    endgenerate

    wire [23:0] r0 = creg_q[0];
    wire [23:0] r1 = creg_q[1];
    wire [23:0] r3 = creg_q[3];
    wire [23:0] r4 = creg_q[4];
    wire [23:0] r5 = creg_q[5];
    // divide values from the loaded counts
    wire [3:0]  rf_main  = r0[sscl_pkg::R0_B_LSB +: 4];
    wire [2:0]  rf_swal  = r0[sscl_pkg::R0_A_LSB +: 3];
    wire [3:0]  rf_mod   = r0[sscl_pkg::R0_RF_SEL] ? sscl_pkg::MOD_HIGH
                                                   : sscl_pkg::MOD_LOW;
    wire [7:0]  rf_prod  = rf_mod * rf_main;
    wire [6:0]  rf_div_d = 7'(rf_prod + {5'h0, rf_swal});
    wire [8:0]  if_main  = r4[sscl_pkg::R4_B_LSB +: 9];
    wire [3:0]  if_swal  = r4[sscl_pkg::R4_A_LSB +: 4];
    wire [13:0] if_prod  = sscl_pkg::IF_MOD * if_main;
    wire [12:0] if_div_d = 13'(if_prod + {10'h0, if_swal});
    wire [8:0]  if_rcnt  = r5[sscl_pkg::R5_R_LSB +: 9];
    // section gating
    wire rf_on_d = ce_lvl & r1[sscl_pkg::R1_RF_SECTION_ENABLE];
    wire if_on_d = ce_lvl & r1[sscl_pkg::R1_IF_EN];
    // if reference divider: one tick every if_rcnt reference cycles
    logic [8:0] if_rdiv_q;
    wire        if_wrap = (if_rdiv_q + 9'd1 >= if_rcnt);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            if_rdiv_q       <= '0;
            if_compare_tick <= 1'b0;
        end else if (clk_en) begin
            if_rdiv_q       <= (if_wrap || !if_on_d) ? 9'd0 : if_rdiv_q + 9'd1;
            if_compare_tick <= if_wrap & if_on_d;
        end
    end
    // lock detect: timestamp the 64th rising edge of each divided signal
    logic [9:0] timer_q;
    logic [5:0] ref_cnt_q, fb_cnt_q;
    logic [9:0] ref_ts_q, fb_ts_q;
    logic       ref_hit_q, fb_hit_q;
    wire        ref_cap = ref_up & (ref_cnt_q == sscl_pkg::CMP_LAST);
    wire        fb_cap  = fb_up & (fb_cnt_q == sscl_pkg::CMP_LAST);
    wire        compare = ref_hit_q & fb_hit_q;
    wire [9:0]  err_raw = ref_ts_q - fb_ts_q;  // modular, so a timer wrap is harmless
    wire [9:0]  err_abs = err_raw[9] ? 10'd0 - err_raw : err_raw;
    wire        good = err_abs < 10'(sscl_pkg::LOCK_WIN_CYC);
    wire        bad  = err_abs >= 10'(sscl_pkg::UNLOCK_WIN_CYC);

    // edge counters and captures; a new capture wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_q   <= '0;
            ref_cnt_q <= '0;
            fb_cnt_q  <= '0;
            ref_ts_q  <= '0;
            fb_ts_q   <= '0;
            ref_hit_q <= 1'b0;
            fb_hit_q  <= 1'b0;
        end else if (clk_en) begin
            timer_q   <= timer_q + 10'd1;
            ref_cnt_q <= ref_cnt_q + 6'(ref_up);
            fb_cnt_q  <= fb_cnt_q + 6'(fb_up);
            if (ref_cap) begin
                ref_ts_q <= timer_q;
            end
            if (fb_cap) begin
                fb_ts_q <= timer_q;
            end
            ref_hit_q <= ref_cap | (ref_hit_q & ~compare);
            fb_hit_q  <= fb_cap | (fb_hit_q & ~compare);
        end
    end

    // lock state machine
    sscl_pkg::sscl_ld_e ld_q, ld_d;
    logic [2:0] good_q, good_d;
    logic [9:0] last_err_q;
    always_comb begin
        ld_d   = ld_q;
        good_d = good_q;
        if (compare) begin
            if (bad) begin
                good_d = 3'd0;
            end else if (good_q < sscl_pkg::LOCK_COUNT) begin
                good_d = good_q + 3'd1;
            end
        end
        case (ld_q)
            sscl_pkg::LD_UNLOCKED: begin
                if (compare && good && good_d >= sscl_pkg::LOCK_COUNT) begin
                    ld_d = sscl_pkg::LD_LOCKED;
                end
            end
            sscl_pkg::LD_LOCKED: begin
                if (compare && bad) begin
                    ld_d = sscl_pkg::LD_UNLOCKED;
                end
            end
            default: ld_d = sscl_pkg::LD_UNLOCKED;
        endcase
        if (!rf_on_d) begin
            ld_d   = sscl_pkg::LD_UNLOCKED;  // no loop while powered down
            good_d = 3'd0;
        end
    end

    wire locked_d = (ld_d == sscl_pkg::LD_LOCKED);
    wire lock_gain = locked_d & (ld_q != sscl_pkg::LD_LOCKED);
    wire [1:0] spur_mode = r1[sscl_pkg::R1_SPUR_LSB +: 2];
    wire spur_d = ((spur_mode == sscl_pkg::SPUR_CONT) & compare & locked_d)
                | ((spur_mode == sscl_pkg::SPUR_ONCE) & lock_gain);
    wire r0_load = any_load & (new_idx == 3'd0);

    // lock, spur and bandwidth outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_q               <= sscl_pkg::LD_UNLOCKED;
            good_q             <= '0;
            last_err_q         <= '0;
            lock_indicator_out <= 1'b0;
            spur_comp_update   <= 1'b0;
            wide_bandwidth     <= 1'b0;
        end else if (clk_en) begin
            ld_q       <= ld_d;
            good_q     <= good_d;
            if (compare) begin
                last_err_q <= err_abs;
            end
            lock_indicator_out <= r0[sscl_pkg::R0_LD_MODE] & locked_d;
            spur_comp_update   <= spur_d;
            if (!r3[sscl_pkg::R3_WIDE_BANDWIDTH_ENABLE] || locked_d) begin
                wide_bandwidth <= 1'b0;
            end else if (r0_load) begin
                wide_bandwidth <= 1'b1;
            end
        end
    end

    // section and divider outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_section_enable       <= 1'b0;
            if_section_enable       <= 1'b0;
            rf_divide_value         <= '0;
            rf_fraction_numerator   <= '0;
            if_divide_value         <= '0;
            wide_bandwidth_duration <= '0;
            wide_bandwidth_control  <= '0;
        end else if (clk_en) begin
            rf_section_enable       <= rf_on_d;
            if_section_enable       <= if_on_d;
            rf_divide_value         <= rf_div_d;
            rf_fraction_numerator   <= r0[sscl_pkg::R0_FN_LSB +: 11];
            if_divide_value         <= if_div_d;
            wide_bandwidth_duration <= r3[sscl_pkg::R3_DUR_LSB +: 2];
            wide_bandwidth_control  <= r3[sscl_pkg::R3_CRL_LSB +: 2];
        end
    end

    // read decode
    wire [7:0]  creg_off = a_lo - sscl_pkg::OFS_CREG_BASE;
    wire        creg_hit = (a_lo >= sscl_pkg::OFS_CREG_BASE) &&
                           (creg_off[7:2] < 6'(NUM_CREG)) && (a_lo[1:0] == 2'b00);
    wire [2:0]  creg_rix = creg_off[4:2];
    wire [31:0] status_w = {25'h0, good_q, if_section_enable, rf_section_enable,
                            lock_indicator_out, ld_q == sscl_pkg::LD_LOCKED};
    wire [31:0] rd_w = (a_lo == sscl_pkg::OFS_STATUS)    ? status_w :
                       (a_lo == sscl_pkg::OFS_PHASE_ERR) ? {22'h0, last_err_q} :
                       creg_hit ? {8'h0, creg_q[creg_rix]} : 32'h0000_0000;

    // bus handshake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            wr_pend_q <= take & hwrite;
            wr_addr_q <= a_lo;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (take && !hwrite) begin
                hrdata <= rd_w;
            end
        end
    end

endmodule // sscl_top

// File: sscl_monitor.sv
// checker for bus, power gating, divider and lock output relations
// sees only top-level ports; bound onto sscl_top after the module
`timescale 1ns/1ps

module sscl_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        serial_load_strobe,
    input wire logic        chip_enable_pin,
    input wire logic        ref_divided,
    input wire logic        rf_section_enable,
    input wire logic        if_section_enable,
    input wire logic        lock_indicator_out,
    input wire logic [6:0]  rf_divide_value,
    input wire logic [12:0] if_divide_value,
    input wire logic        if_compare_tick
);
    logic [4:0] load_age_q;  // cycles since a load strobe or any bus write
    logic [3:0] ce_low_q;    // cycles chip enable low
    logic [9:0] ref_cnt_q;   // ref rises since lock fell
    logic       ref_prev_q;  // ref one cycle back
    wire        wr_taken   = hsel && htrans[1] && hwrite && hready;
    wire        rd_taken   = hsel && htrans[1] && !hwrite && hready;
    wire        ref_rise   = ref_divided && !ref_prev_q;
    // counters saturate so a long run never wraps into a false pass
    wire  [4:0] load_age_d = (serial_load_strobe || wr_taken) ? 5'h00 :
                             load_age_q + {4'h0, load_age_q != 5'h1f};
    wire  [3:0] ce_low_d   = chip_enable_pin ? 4'h0 : ce_low_q + {3'h0, ce_low_q != 4'hf};
    wire  [9:0] ref_cnt_d  = ref_cnt_q + {9'h0, ref_rise && ref_cnt_q != 10'h3ff};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // helper counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_age_q <= 5'h1f;
            ce_low_q   <= 4'h0;
            ref_cnt_q  <= 10'h000;
            ref_prev_q <= 1'b0;
        end else begin
            load_age_q <= load_age_d;
            ce_low_q   <= ce_low_d;
            ref_cnt_q  <= $fell(lock_indicator_out) ? 10'h000 : ref_cnt_d;
            ref_prev_q <= ref_divided;
        end
    end

    // rf held off for three cycles
    sequence s_rf_off;
        !rf_section_enable [*3];
    endsequence

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    rd_data_hold_a: assert property ($changed(hrdata) |-> $past(rd_taken))
        else $error("read data moved without a read");
    power_gate_a: assert property (ce_low_q >= 4'h8 |->
        !rf_section_enable && !if_section_enable && !lock_indicator_out)
        else $error("section on with chip enable low");
    lock_rf_off_a: assert property (s_rf_off |-> !lock_indicator_out)
        else $error("lock shown with rf off");
    lock_rise_late_a: assert property ($rose(lock_indicator_out) |->
        ref_cnt_q >= 10'h0fa)
        else $error("lock rose before four comparisons");
    rf_div_hold_a: assert property ($changed(rf_divide_value) |->
        load_age_q <= 5'h0c)
        else $error("rf divide changed without a load");
    if_div_hold_a: assert property ($changed(if_divide_value) |->
        load_age_q <= 5'h0c)
        else $error("if divide changed without a load");
    if_tick_on_a: assert property (if_compare_tick |->
        if_section_enable || $past(if_section_enable))
        else $error("if tick with if section off");
endmodule // sscl_monitor

bind sscl_top sscl_monitor i_sscl_monitor (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .serial_load_strobe, .chip_enable_pin,
    .ref_divided, .rf_section_enable, .if_section_enable, .lock_indicator_out,
    .rf_divide_value, .if_divide_value, .if_compare_tick);

// File: sscl_host.sv
// host model driving the three-wire serial programming port
// assumes callers enter send_word just after a rising hclk edge
`timescale 1ns/1ps

module sscl_host (
    input  wire logic hclk,
    output logic      serial_data,
    output logic      serial_clock,
    output logic      serial_load_strobe
);
    // lines idle low, as when the device is powered down
    initial begin
        serial_data        = 1'b0;
        serial_clock       = 1'b0;
        serial_load_strobe = 1'b0;
    end

    // four cycles per level clears the three-stage pin filter
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data  <= w[i];
            serial_clock <= 1'b0;
            repeat (4) @(posedge hclk);
            serial_clock <= 1'b1;
            repeat (4) @(posedge hclk);
        end
        serial_clock       <= 1'b0;
        serial_data        <= 1'b0;
        repeat (4) @(posedge hclk);
        serial_load_strobe <= 1'b1;
        repeat (4) @(posedge hclk);
        serial_load_strobe <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
endmodule // sscl_host

// File: sscl_top_tb.sv
// top testbench: bus, serial and lock-detect scenarios
// assumes sscl_top, sscl_host and the bound monitor are compiled first
`timescale 1ns/1ps

module sscl_top_tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, div_run;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, ph_q;
    logic        serial_data, serial_clock, serial_load_strobe, chip_enable_pin;
    logic        ref_divided, fb_divided, rf_section_enable, if_section_enable;
    logic        lock_indicator_out, if_compare_tick;
    logic [6:0]  rf_divide_value;
    logic [10:0] rf_fraction_numerator;
    logic [12:0] if_divide_value;
    logic        clk_en, spur_comp_update, wide_bandwidth;  // freeze and loop assist
    logic [1:0]  wide_bandwidth_duration, wide_bandwidth_control;
    logic [7:0]  hist_q;  // ref history for the feedback lag
    int          lag, err_count, comparisons, ticks, spurs;
    wire  [2:0]  ph_n   = ph_q + 3'h1;
    wire  [7:0]  hist_n = {hist_q[6:0], ph_n[2]};

    sscl_top i_sscl_top (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_data,
        .serial_clock, .serial_load_strobe, .chip_enable_pin, .ref_divided, .fb_divided,
        .rf_section_enable, .if_section_enable, .lock_indicator_out, .rf_divide_value,
        .rf_fraction_numerator, .if_divide_value, .if_compare_tick, .spur_comp_update,
        .wide_bandwidth, .wide_bandwidth_duration, .wide_bandwidth_control);
    sscl_host i_host (.hclk, .serial_data, .serial_clock, .serial_load_strobe);

    // 40 MHz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // divided ref: 8-cycle period; fb trails it by lag cycles
    always @(posedge hclk) begin
        if (div_run) begin
            ph_q        <= ph_n;
            hist_q      <= hist_n;
            ref_divided <= ph_n[2];
            fb_divided  <= hist_n[lag];
        end
    end

    // spur compensation pulses, counted over the whole run
    always @(posedge hclk) begin
        if (spur_comp_update === 1'b1)
            spurs++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // single ahb-lite transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // wait for a spot where ref has been low long enough to switch lag cleanly
    task automatic align;
        do @(posedge hclk); while (ph_q !== 3'h2);
    endtask

    task automatic test_done;
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog, far beyond the expected run of some 6100 cycles
    initial begin
        cyc(20000);
        err_count++;
        test_done;
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        chip_enable_pin = 1'b1;
        ref_divided = 1'b0;
        fb_divided = 1'b0;
        div_run = 1'b0;
        clk_en = 1'b1;
        ph_q = 3'h0;
        hist_q = 8'h00;
        cyc(4);
        hresetn <= 1'b1;
        cyc(4);
        rd_chk(8'h00, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
        xfer(1'b1, 8'h00, 32'h0000_00ff);
        rd_chk(8'h00, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);
        i_host.send_word(24'hd8_0003);
        i_host.send_word(24'h00_0002);
        i_host.send_word(24'h00_100d);
        i_host.send_word(24'h65_6190);
        cyc(8);
        rd_chk(8'h24, 32'h0000_100d);
        rd_chk(8'h20, 32'h0065_6190);
        check(32'(rf_divide_value), 32'h0000_002b);
        check(32'(rf_fraction_numerator), 32'h0000_0064);
        check(32'({wide_bandwidth, wide_bandwidth_duration, wide_bandwidth_control}),
              32'h0000_001d);
        // every chip-enable and enable-bit combination
        for (int k = 0; k < 8; k++) begin
            chip_enable_pin <= k[2];
            xfer(1'b1, 8'h04, 32'h0000_1001 | (32'(k[1:0]) << 2));
            cyc(8);
            check(32'({rf_section_enable, if_section_enable}),
                  32'({k[2] & k[1], k[2] & k[0]}));
        end
        // a frozen block must ignore a write that would switch both sections off
        clk_en <= 1'b0;
        xfer(1'b1, 8'h04, 32'h0000_1001);
        clk_en <= 1'b1;
        cyc(4);
        check(32'({rf_section_enable, if_section_enable}), 32'h0000_0003);
        xfer(1'b1, 8'h04, 32'h0001_2e57);
        xfer(1'b1, 8'h04, 32'h0000_004f);
        cyc(4);
        check(32'(if_divide_value), 32'h0000_0e59);
        rd_chk(8'h30, 32'h0001_2e57);
        ticks = 0;
        repeat (20) begin
            @(posedge hclk);
            if (if_compare_tick === 1'b1)
                ticks++;
        end
        check(32'(ticks), 32'h0000_000a);
        // lock detect: comparisons every 512 cycles
        div_run <= 1'b1;
        cyc(1792);
        check(32'(lock_indicator_out), 32'h0000_0000);
        cyc(512);
        check(32'(lock_indicator_out), 32'h0000_0001);
        check(32'(wide_bandwidth), 32'h0000_0000);
        align;
        lag <= 2;
        cyc(512);
        check(32'(lock_indicator_out), 32'h0000_0000);
        align;
        lag <= 0;
        cyc(1536);
        check(32'(lock_indicator_out), 32'h0000_0000);
        cyc(512);
        check(32'(lock_indicator_out), 32'h0000_0001);
        check(32'(spurs), 32'h0000_0002);
        i_host.send_word(24'h45_6190);
        cyc(8);
        check(32'(lock_indicator_out), 32'h0000_0000);
        rd_chk(8'h00, 32'h0000_004d);
        chip_enable_pin <= 1'b0;
        cyc(10);
        check(32'({rf_section_enable, if_section_enable, lock_indicator_out}),
              32'h0000_0000);
        test_done;
    end
endmodule // sscl_top_tb
